// ---- core/gimlb_top.sv ----
// Global interrupt vector mask, vector status and framer loopback registers
`include "gimlb_consts.svh"
`default_nettype none
module gimlb_top #(
	parameter int NFR = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,

	// Host parallel port
	input wire logic host_cs_n,
	input wire logic host_rd_n,
	input wire logic host_wr_n,
	input wire logic [11:0] host_addr,
	input wire logic [15:0] host_data_in,
	output logic [15:0] host_data_out,
	output logic host_data_oe,

	// Rate selection pin, high for 8.192 Mbit/s
	input wire logic rate_8m_sel,

	// Per-framer interrupt sources, any-bit-set summaries
	input wire logic [NFR-1:0] fr_sync_src,
	input wire logic [NFR-1:0] fr_rxline_src,
	input wire logic [NFR-1:0] fr_elastic_src,
	input wire logic [NFR-1:0] fr_elastic_stat,
	input wire logic [NFR-1:0] fr_hdlc_src,

	// Aggregated vector status
	output logic [4*NFR-1:0] vector_status,

	// Backplane streams
	input wire logic [NFR-1:0] fr_backplane_serial_out,
	output logic [NFR-1:0] backplane_serial_out,
	input wire logic [NFR-1:0] backplane_serial_in,
	output logic [NFR-1:0] fr_backplane_serial_in,

	// Line streams
	input wire logic [NFR-1:0] fr_line_tx_positive,
	input wire logic [NFR-1:0] fr_line_tx_negative,
	output logic [NFR-1:0] line_tx_positive,
	output logic [NFR-1:0] line_tx_negative,
	input wire logic [NFR-1:0] line_rx_positive,
	input wire logic [NFR-1:0] line_rx_negative,
	output logic [NFR-1:0] fr_line_rx_positive,
	output logic [NFR-1:0] fr_line_rx_negative
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [2:0] ctl_s1_q;
	logic [2:0] ctl_s2_q;
	logic [11:0] addr_s1_q;
	logic [11:0] addr_s2_q;
	logic [15:0] din_s1_q;
	logic [15:0] din_s2_q;
	logic rate_s1_q;
	logic rate_s2_q;
	logic [NFR-1:0] bpi_s1_q;
	logic [NFR-1:0] bpi_s2_q;
	logic [NFR-1:0] rxp_s1_q;
	logic [NFR-1:0] rxp_s2_q;
	logic [NFR-1:0] rxn_s1_q;
	logic [NFR-1:0] rxn_s2_q;

	// Host strobes, address and data pass two stages before use
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctl_s1_q <= 3'h7;
			ctl_s2_q <= 3'h7;
			addr_s1_q <= 12'h000;
			addr_s2_q <= 12'h000;
			din_s1_q <= 16'h0000;
			din_s2_q <= 16'h0000;
			rate_s1_q <= 1'b0;
			rate_s2_q <= 1'b0;
		end else begin
			ctl_s1_q <= {host_cs_n, host_rd_n, host_wr_n};
			ctl_s2_q <= ctl_s1_q;
			addr_s1_q <= host_addr;
			addr_s2_q <= addr_s1_q;
			din_s1_q <= host_data_in;
			din_s2_q <= din_s1_q;
			rate_s1_q <= rate_8m_sel;
			rate_s2_q <= rate_s1_q;
		end
	end

	// Receive pins from the outside world
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bpi_s1_q <= '0;
			bpi_s2_q <= '0;
			rxp_s1_q <= '0;
			rxp_s2_q <= '0;
			rxn_s1_q <= '0;
			rxn_s2_q <= '0;
		end else begin
			bpi_s1_q <= backplane_serial_in;
			bpi_s2_q <= bpi_s1_q;
			rxp_s1_q <= line_rx_positive;
			rxp_s2_q <= rxp_s1_q;
			rxn_s1_q <= line_rx_negative;
			rxn_s2_q <= rxn_s1_q;
		end
	end

	// ****************************************
	// Host access sequencing
	// ****************************************
	logic cs_act;
	logic rd_act;
	logic wr_act;
	logic wr_commit;
	gimlb_pkg::gimlb_state_t state_q;
	gimlb_pkg::gimlb_state_t state_d;

	assign cs_act = !ctl_s2_q[2];
	assign rd_act = cs_act && !ctl_s2_q[1];
	assign wr_act = cs_act && !ctl_s2_q[0];
	// Data is taken when the write strobe ends, so the bus has settled
	assign wr_commit = (state_q == gimlb_pkg::ST_WRITE) && !wr_act;

	// Next access state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			gimlb_pkg::ST_IDLE: begin
				if (wr_act) begin
					state_d = gimlb_pkg::ST_WRITE;
				end else if (rd_act) begin
					state_d = gimlb_pkg::ST_READ;
				end
			end
			gimlb_pkg::ST_WRITE: begin
				if (!wr_act) begin
					state_d = gimlb_pkg::ST_IDLE;
				end
			end
			gimlb_pkg::ST_READ: begin
				if (!rd_act) begin
					state_d = gimlb_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = gimlb_pkg::ST_IDLE;
			end
		endcase
	end

	// Access state register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= gimlb_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Address and data follow the bus while the write strobe is low, then hold
	logic [11:0] wr_addr_q;
	logic [15:0] wr_data_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_addr_q <= 12'h000;
			wr_data_q <= 16'h0000;
		end else if (wr_act) begin
			wr_addr_q <= addr_s2_q;
			wr_data_q <= din_s2_q;
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	logic [15:0] mask_one_q;
	logic [15:0] mask_two_q;
	logic [15:0] loop_q;

	// Vector masks, cleared at reset so nothing is masked
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mask_one_q <= `GIMLB_MASK_RST;
			mask_two_q <= `GIMLB_MASK_RST;
		end else if (wr_commit) begin
			if (wr_addr_q == `GIMLB_ADDR_MASK_ONE) begin
				mask_one_q <= wr_data_q;
			end
			if (wr_addr_q == `GIMLB_ADDR_MASK_TWO) begin
				mask_two_q <= wr_data_q;
			end
		end
	end

	// Loopback register; unused low bits never store
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			loop_q <= `GIMLB_LOOP_RST;
		end else if (wr_commit && wr_addr_q == `GIMLB_ADDR_LOOPBACK) begin
			loop_q <= wr_data_q & `GIMLB_LOOP_WMASK;
		end
	end

	// ****************************************
	// Vector status
	// ****************************************
	logic [4*NFR-1:0] mask_all;
	logic [4*NFR-1:0] src_all;
	logic [4*NFR-1:0] status_q;

	assign mask_all = {mask_two_q, mask_one_q};

	// Place each framer's four sources at its nibble
	function automatic int vec_pos(input int fr, input int kind);
		vec_pos = fr * `GIMLB_BITS_PER_FR + kind;
	endfunction

	// Gather sources; elastic store status joins the elastic source
	always_comb begin
		src_all = '0;
		for (int f = 0; f < NFR; f++) begin
			src_all[vec_pos(f, `GIMLB_KIND_SYNC)] = fr_sync_src[f];
			src_all[vec_pos(f, `GIMLB_KIND_RXLINE)] = fr_rxline_src[f];
			src_all[vec_pos(f, `GIMLB_KIND_ELASTIC)] = fr_elastic_src[f] | fr_elastic_stat[f];
			src_all[vec_pos(f, `GIMLB_KIND_HDLC)] = fr_hdlc_src[f];
		end
	end

	// Level status, no latching: a masked bit reads zero one clock after the mask register loads
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			status_q <= '0;
		end else begin
			status_q <= src_all & ~mask_all;
		end
	end

	assign vector_status = status_q;

	// ****************************************
	// Read data
	// ****************************************
	logic [15:0] rd_mux;
	logic [15:0] rdata_q;
	logic oe_q;

	// Unmapped addresses read as zero
	always_comb begin
		unique case (addr_s2_q)
			`GIMLB_ADDR_MASK_ONE: rd_mux = mask_one_q;
			`GIMLB_ADDR_MASK_TWO: rd_mux = mask_two_q;
			`GIMLB_ADDR_LOOPBACK: rd_mux = loop_q & `GIMLB_LOOP_WMASK;
			`GIMLB_ADDR_STAT_ONE: rd_mux = status_q[15:0];
			`GIMLB_ADDR_STAT_TWO: rd_mux = status_q[31:16];
			default: rd_mux = 16'h0000;
		endcase
	end

	// Read data and drive enable follow the synced read strobe
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= 16'h0000;
			oe_q <= 1'b0;
		end else begin
			rdata_q <= rd_act ? rd_mux : 16'h0000;
			oe_q <= rd_act;
		end
	end

	assign host_data_out = rdata_q;
	assign host_data_oe = oe_q;

	// ****************************************
	// Loopback cross-connect
	// ****************************************
	gimlb_xc_if #(.NFR(NFR)) xc_bus ();

	// One driver for the whole control word; per-field assigns would multiply drive it
	assign xc_bus.loop = {loop_q[`GIMLB_BP_ALL_BIT], loop_q[`GIMLB_BP_PAIR_LSB +: 4],
		loop_q[`GIMLB_LN_ALL_BIT], loop_q[`GIMLB_LN_PAIR_LSB +: 4]};
	assign xc_bus.rate_8m = rate_s2_q;
	assign xc_bus.bp_out = fr_backplane_serial_out;
	assign xc_bus.bp_in_pin = bpi_s2_q;
	assign xc_bus.tx_p = fr_line_tx_positive;
	assign xc_bus.tx_n = fr_line_tx_negative;
	assign xc_bus.rx_p_pin = rxp_s2_q;
	assign xc_bus.rx_n_pin = rxn_s2_q;

	gimlb_xconn #(.NFR(NFR)) u_xconn (
		.xc (xc_bus.xc)
	);

	// Streams leave through flip-flops; pins keep carrying framer output during loops
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			backplane_serial_out <= '0;
			line_tx_positive <= '0;
			line_tx_negative <= '0;
			fr_backplane_serial_in <= '0;
			fr_line_rx_positive <= '0;
			fr_line_rx_negative <= '0;
		end else begin
			backplane_serial_out <= fr_backplane_serial_out;
			line_tx_positive <= fr_line_tx_positive;
			line_tx_negative <= fr_line_tx_negative;
			fr_backplane_serial_in <= xc_bus.bp_in_fr;
			fr_line_rx_positive <= xc_bus.rx_p_fr;
			fr_line_rx_negative <= xc_bus.rx_n_fr;
		end
	end
endmodule
`default_nettype wire

// ---- core/gimlb_xconn.sv ----
// Backplane and line loopback cross-connect
`default_nettype none
module gimlb_xconn #(
	parameter int NFR = 8
) (
	// Control and data
	gimlb_xc_if.xc xc
);
	// ****************************************
	// Partner selection
	// ****************************************
	// Framer 0 and framer 4 are the far ends of the all-framer loops
	function automatic logic far_index(input logic [2:0] idx, input logic [2:0] peer);
		far_index = (idx == 3'h0 && peer == 3'h4) || (idx == 3'h4 && peer == 3'h0);
	endfunction

	// Each receive input takes its pin unless a loop names a partner
	always_comb begin
		logic [2:0] i3;
		logic [2:0] pr;
		i3 = 3'h0;
		pr = 3'h0;
		for (int i = 0; i < NFR; i++) begin
			i3 = 3'(i);
			pr = i3 ^ 3'h4;
			xc.bp_in_fr[i] = xc.bp_in_pin[i];
			xc.rx_p_fr[i] = xc.rx_p_pin[i];
			xc.rx_n_fr[i] = xc.rx_n_pin[i];
			// Backplane: the rate-independent loop wins over a pair loop
			if (xc.loop.bp_all && far_index(i3, pr)) begin
				xc.bp_in_fr[i] = xc.bp_out[pr];
			end else if (xc.loop.bp_pair[i/2] && !xc.rate_8m) begin
				xc.bp_in_fr[i] = xc.bp_out[i ^ 1];
			end
			// Line side follows the same precedence
			if (xc.loop.ln_all && far_index(i3, pr)) begin
				xc.rx_p_fr[i] = xc.tx_p[pr];
				xc.rx_n_fr[i] = xc.tx_n[pr];
			end else if (xc.loop.ln_pair[i/2] && !xc.rate_8m) begin
				xc.rx_p_fr[i] = xc.tx_p[i ^ 1];
				xc.rx_n_fr[i] = xc.tx_n[i ^ 1];
			end
		end
	end
endmodule
`default_nettype wire

// ---- dv/gimlb_top_sva.sv ----
// Assertion checker for the global mask, vector status and loopback block
`default_nettype none
module gimlb_top_sva #(
	parameter int NFR = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Host port
	input wire logic host_cs_n,
	input wire logic host_rd_n,
	input wire logic [11:0] host_addr,
	input wire logic [15:0] host_data_out,
	input wire logic host_data_oe,
	input wire logic rate_8m_sel,
	// Sources and status
	input wire logic [NFR-1:0] fr_sync_src,
	input wire logic [NFR-1:0] fr_rxline_src,
	input wire logic [NFR-1:0] fr_elastic_src,
	input wire logic [NFR-1:0] fr_elastic_stat,
	input wire logic [NFR-1:0] fr_hdlc_src,
	input wire logic [4*NFR-1:0] vector_status,
	// Streams
	input wire logic [NFR-1:0] backplane_serial_in,
	input wire logic [NFR-1:0] fr_backplane_serial_in,
	input wire logic [NFR-1:0] line_rx_positive,
	input wire logic [NFR-1:0] fr_line_rx_positive
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Helper logic
	// ****
	logic [4*NFR-1:0] src_vec;
	logic [2:0] up_q;
	// Sources laid out as the vector register
	always_comb begin
		for (int f = 0; f < NFR; f++) begin
			src_vec[4*f +: 4] = {fr_hdlc_src[f], fr_elastic_src[f] | fr_elastic_stat[f],
				fr_rxline_src[f], fr_sync_src[f]};
		end
	end
	// Cycles since reset; pin history before that is meaningless
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			up_q <= 3'h0;
		end else if (up_q != 3'h7) begin
			up_q <= up_q + 3'h1;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_rd_fall;
		$fell(host_rd_n) && !host_cs_n;
	endsequence
	sequence s_fast;
		(rate_8m_sel && up_q == 3'h7) [*5];
	endsequence
	// ****
	// Properties
	// ****
	property p_mask_gate;
		(vector_status & ~$past(src_vec)) == '0;
	endproperty
	property p_rst_clear;
		$rose(nrst) |-> vector_status == '0 && !host_data_oe;
	endproperty
	property p_oe_rise;
		s_rd_fall |-> ##2 !host_data_oe ##1 host_data_oe;
	endproperty
	property p_oe_cause;
		$rose(host_data_oe) |-> !$past(host_rd_n, 3) && !$past(host_cs_n, 3);
	endproperty
	property p_out_idle;
		!host_data_oe |-> host_data_out == 16'h0000;
	endproperty
	property p_loop_unused;
		host_data_oe && $past(host_addr, 3) == 12'h904 && $past(host_addr, 4) == 12'h904
			|-> host_data_out[5:0] == 6'h00;
	endproperty
	property p_unmapped;
		host_data_oe && $past(host_addr, 3) > 12'h911 && $past(host_addr, 4) > 12'h911
			|-> host_data_out == 16'h0000;
	endproperty
	property p_bp_fast;
		s_fast |-> (fr_backplane_serial_in & 8'hEE) == ($past(backplane_serial_in, 3) & 8'hEE);
	endproperty
	property p_ln_fast;
		s_fast |-> (fr_line_rx_positive & 8'hEE) == ($past(line_rx_positive, 3) & 8'hEE);
	endproperty
	a_mask_gate: assert property (p_mask_gate)
		else $error("status bit set without its source");
	a_rst_clear: assert property (p_rst_clear)
		else $error("status or bus drive active after reset");
	a_oe_rise: assert property (p_oe_rise)
		else $error("read drive not on the third edge");
	a_oe_cause: assert property (p_oe_cause)
		else $error("read drive without a read strobe");
	a_out_idle: assert property (p_out_idle)
		else $error("read data not zero while idle");
	a_loop_unused: assert property (p_loop_unused)
		else $error("unused loopback bits read nonzero");
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped address read nonzero");
	a_bp_fast: assert property (p_bp_fast)
		else $error("backplane pair loop active at fast rate");
	a_ln_fast: assert property (p_ln_fast)
		else $error("line pair loop active at fast rate");
endmodule
bind gimlb_top gimlb_top_sva #(.NFR(NFR)) u_sva (.clk(clk), .nrst(nrst),
	.host_cs_n(host_cs_n), .host_rd_n(host_rd_n), .host_addr(host_addr),
	.host_data_out(host_data_out), .host_data_oe(host_data_oe), .rate_8m_sel(rate_8m_sel),
	.fr_sync_src(fr_sync_src), .fr_rxline_src(fr_rxline_src), .fr_elastic_src(fr_elastic_src),
	.fr_elastic_stat(fr_elastic_stat), .fr_hdlc_src(fr_hdlc_src), .vector_status(vector_status),
	.backplane_serial_in(backplane_serial_in), .fr_backplane_serial_in(fr_backplane_serial_in),
	.line_rx_positive(line_rx_positive), .fr_line_rx_positive(fr_line_rx_positive));
`default_nettype wire

// ---- dv/gimlb_top_tb.sv ----
// Self-checking bench for the global mask, vector status and loopback block
`default_nettype none
module gimlb_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk;
	logic nrst;
	logic host_cs_n;
	logic host_rd_n;
	logic host_wr_n;
	logic [11:0] host_addr;
	logic [15:0] host_data_in;
	logic [15:0] host_data_out;
	logic host_data_oe;
	logic rate_8m_sel;
	logic [7:0] src [5];
	logic [31:0] vector_status;
	logic [7:0] bpo, bpi, tp, tn, rpi, rni, bp_pin, bp_fr, rp_fr, rn_fr, tp_pin, tn_pin;
	logic [15:0] rd_q, m1, m2, lpw;
	logic [31:0] e;
	logic [31:0] rs = 32'hAACD;
	int failures = 0;
	int total_checks = 0;
	int cyc = 0;

	gimlb_top #(.NFR(8)) dut (.clk(clk), .nrst(nrst), .host_cs_n(host_cs_n),
		.host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .host_addr(host_addr),
		.host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
		.rate_8m_sel(rate_8m_sel), .fr_sync_src(src[0]), .fr_rxline_src(src[1]),
		.fr_elastic_src(src[2]), .fr_elastic_stat(src[3]), .fr_hdlc_src(src[4]),
		.vector_status(vector_status), .fr_backplane_serial_out(bpo),
		.backplane_serial_out(bp_pin), .backplane_serial_in(bpi), .fr_backplane_serial_in(bp_fr),
		.fr_line_tx_positive(tp), .fr_line_tx_negative(tn), .line_tx_positive(tp_pin),
		.line_tx_negative(tn_pin), .line_rx_positive(rpi), .line_rx_negative(rni),
		.fr_line_rx_positive(rp_fr), .fr_line_rx_negative(rn_fr));

	// ****
	// Helpers
	// ****
	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	// Expected vector: elastic status folds into the elastic bit
	function automatic logic [31:0] exp_vec(logic [15:0] a, logic [15:0] b);
		logic [31:0] v;
		for (int f = 0; f < 8; f++) begin
			v[4*f +: 4] = {src[4][f], src[2][f] | src[3][f], src[1][f], src[0][f]};
		end
		return v & ~{b, a};
	endfunction
	// Pair loops first so the all-framer loop wins on framers 0 and 4
	function automatic logic [7:0] exp_x(logic [15:0] lp, int all, int lsb, logic [7:0] pin,
		logic [7:0] fo);
		logic [7:0] r;
		r = pin;
		for (int p = 0; p < 4; p++) begin
			if (!rate_8m_sel && lp[lsb+p]) begin
				r[2*p] = fo[2*p+1];
				r[2*p+1] = fo[2*p];
			end
		end
		if (lp[all]) begin
			r[0] = fo[4];
			r[4] = fo[0];
		end
		return r;
	endfunction
	task automatic chk_reg(logic [15:0] got, logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t: register read %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_vec(logic [31:0] got, logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t: vector %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bits(logic [7:0] got, logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t: stream %h, expected %h", $time, got, exp);
		end
	endtask
	// Strobes held five cycles and gapped five: covers the two-flop sync
	task automatic host_acc(logic wr, logic [11:0] a, logic [15:0] d);
		@(negedge clk);
		host_cs_n = 1'b0;
		host_rd_n = wr;
		host_wr_n = !wr;
		host_addr = a;
		host_data_in = d;
		repeat (5) @(negedge clk);
		rd_q = host_data_out;
		if (!wr) begin
			chk_bits({7'h00, host_data_oe}, 8'h01);
		end
		host_cs_n = 1'b1;
		host_rd_n = 1'b1;
		host_wr_n = 1'b1;
		repeat (5) @(negedge clk);
	endtask
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ****
	// Clock, watchdog, sequence
	// ****
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Runs take about 2000 cycles; a hang ends the run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			wrap_up();
		end
	end
	initial begin
		nrst = 1'b0;
		host_cs_n = 1'b1;
		host_rd_n = 1'b1;
		host_wr_n = 1'b1;
		host_addr = 12'h000;
		host_data_in = 16'h0000;
		rate_8m_sel = 1'b0;
		{bpo, bpi, tp, tn, rpi, rni} = 48'h0;
		for (int k = 0; k < 5; k++) begin
			src[k] = 8'h00;
		end
		repeat (5) @(negedge clk);
		nrst = 1'b1;
		host_acc(1'b0, 12'h903, 16'h0000);
		chk_reg(rd_q, 16'h0000);
		host_acc(1'b1, 12'h904, 16'hFFFF);
		host_acc(1'b0, 12'h904, 16'h0000);
		chk_reg(rd_q, 16'hFFC0);
		host_acc(1'b1, 12'h9A5, 16'hFFFF);
		host_acc(1'b0, 12'h9A5, 16'h0000);
		chk_reg(rd_q, 16'h0000);
		$display("test registers done");
		// Walk mask two bits 0-8 and mask one bits 13-15 with all sources set, then random
		for (int i = 0; i < 24; i++) begin
			m1 = (i < 9) ? 16'h0000 : (i < 12) ? 16'h2000 << (i - 9) : 16'(rnd());
			m2 = (i < 9) ? 16'h0001 << i : (i < 12) ? 16'h0000 : 16'(rnd());
			for (int k = 0; k < 5; k++) begin
				src[k] = (i < 12) ? 8'hFF : 8'(rnd());
			end
			host_acc(1'b1, 12'h902, m1);
			host_acc(1'b1, 12'h903, m2);
			e = exp_vec(m1, m2);
			chk_vec(vector_status, e);
			host_acc(1'b0, 12'h903, 16'h0000);
			chk_reg(rd_q, m2);
			host_acc(1'b1, 12'h910, 16'h5A5A);
			host_acc(1'b0, 12'h910, 16'h0000);
			chk_reg(rd_q, e[15:0]);
			host_acc(1'b0, 12'h911, 16'h0000);
			chk_reg(rd_q, e[31:16]);
		end
		$display("test masking done");
		// Mid-run reset with masks set: everything clears, status follows raw sources
		@(negedge clk);
		nrst = 1'b0;
		@(negedge clk);
		chk_vec(vector_status, 32'h0000_0000);
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		host_acc(1'b0, 12'h902, 16'h0000);
		chk_reg(rd_q, 16'h0000);
		host_acc(1'b0, 12'h903, 16'h0000);
		chk_reg(rd_q, 16'h0000);
		host_acc(1'b0, 12'h904, 16'h0000);
		chk_reg(rd_q, 16'h0000);
		chk_vec(vector_status, exp_vec(16'h0000, 16'h0000));
		$display("test reset done");
		// Each loop bit at both rates, then random mixes
		for (int i = 0; i < 26; i++) begin
			lpw = (i < 20) ? 16'h0040 << (i % 10) : 16'(rnd()) & 16'hFFC0;
			rate_8m_sel = (i / 10 == 1) || (i > 19 && i % 2 == 1);
			{bpo, bpi, tp, tn} = rnd();
			{rpi, rni} = 16'(rnd());
			host_acc(1'b1, 12'h904, lpw);
			chk_bits(bp_fr, exp_x(lpw, 15, 11, bpi, bpo));
			chk_bits(rp_fr, exp_x(lpw, 10, 6, rpi, tp));
			chk_bits(rn_fr, exp_x(lpw, 10, 6, rni, tn));
			chk_bits(bp_pin, bpo);
			chk_bits(tp_pin, tp);
			chk_bits(tn_pin, tn);
		end
		$display("test loopback done");
		wrap_up();
	end
endmodule
`default_nettype wire

// ---- include/gimlb_consts.svh ----
// Constants for the global interrupt mask, vector status and loopback block
`ifndef GIMLB_CONSTS_SVH
`define GIMLB_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define GIMLB_ADDR_MASK_ONE 12'h902
`define GIMLB_ADDR_MASK_TWO 12'h903
`define GIMLB_ADDR_LOOPBACK 12'h904
`define GIMLB_ADDR_STAT_ONE 12'h910
`define GIMLB_ADDR_STAT_TWO 12'h911

// ****************************************
// Reset values and writable bits
// ****************************************
`define GIMLB_MASK_RST 16'h0000
`define GIMLB_LOOP_RST 16'h0000
`define GIMLB_LOOP_WMASK 16'hFFC0

// ****************************************
// Loopback field positions
// ****************************************
`define GIMLB_BP_ALL_BIT 15
`define GIMLB_BP_PAIR_LSB 11
`define GIMLB_LN_ALL_BIT 10
`define GIMLB_LN_PAIR_LSB 6

// ****************************************
// Vector layout: four bits per framer
// ****************************************
`define GIMLB_KIND_SYNC 0
`define GIMLB_KIND_RXLINE 1
`define GIMLB_KIND_ELASTIC 2
`define GIMLB_KIND_HDLC 3
`define GIMLB_BITS_PER_FR 4

`endif

// ---- include/gimlb_pkg.sv ----
// Types shared by the global interrupt mask and loopback block
`default_nettype none
package gimlb_pkg;
	// Host port access state, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_WRITE = 3'h2,
		ST_READ = 3'h4
	} gimlb_state_t;

	// Loopback controls as seen by the cross-connect
	typedef struct packed {
		logic bp_all;
		logic [3:0] bp_pair;
		logic ln_all;
		logic [3:0] ln_pair;
	} gimlb_loop_t;
endpackage
`default_nettype wire

// ---- include/gimlb_xc_if.sv ----
// Signals between the register bank and the loopback cross-connect
`default_nettype none
interface gimlb_xc_if #(parameter int NFR = 8);
	gimlb_pkg::gimlb_loop_t loop;
	logic rate_8m;
	logic [NFR-1:0] bp_out;
	logic [NFR-1:0] bp_in_pin;
	logic [NFR-1:0] bp_in_fr;
	logic [NFR-1:0] tx_p;
	logic [NFR-1:0] tx_n;
	logic [NFR-1:0] rx_p_pin;
	logic [NFR-1:0] rx_n_pin;
	logic [NFR-1:0] rx_p_fr;
	logic [NFR-1:0] rx_n_fr;

	modport ctl (output loop, rate_8m, bp_out, bp_in_pin, tx_p, tx_n, rx_p_pin, rx_n_pin,
		input bp_in_fr, rx_p_fr, rx_n_fr);
	modport xc (input loop, rate_8m, bp_out, bp_in_pin, tx_p, tx_n, rx_p_pin, rx_n_pin,
		output bp_in_fr, rx_p_fr, rx_n_fr);
endinterface
`default_nettype wire
